// file: hdl/nif_pkg.sv
// constants, state types and register map of the node identification indicator framer
// assumes a single 20 MHz core clock and an AXI4-Lite master on the register side
package nif_pkg;
   localparam logic [7:0]  SOF_BYTE    = 8'h7E;
   localparam logic [7:0]  FRAME_TYPE  = 8'h95;
   localparam logic [15:0] RSVD_FILL   = 16'hFFFE;
   localparam logic [7:0]  OPT_BCAST   = 8'h02;
   localparam logic [7:0]  OPT_KEEP    = 8'hC8;
   localparam logic [7:0]  NUL_BYTE    = 8'h00;
   localparam logic [7:0]  PAD_CHAR    = 8'h20;
   localparam logic [7:0]  CKS_BASE    = 8'hFF;
   localparam logic [4:0]  SUM_FROM    = 5'h03;
   localparam logic [4:0]  HDR_LAST    = 5'h18;
   localparam logic [4:0]  TAIL_LAST_S = 5'h07;
   localparam logic [4:0]  TAIL_LAST_L = 5'h0B;
   localparam int          LBL_DEPTH   = 20;
   localparam logic [4:0]  LBL_MAX     = 5'h14;
   localparam logic [15:0] LEN_BASE    = 16'h001E;
   localparam logic [15:0] LEN_DTYPE   = 16'h0004;
   localparam logic [15:0] LEN_RSSI    = 16'h0001;
   localparam logic [7:0]  CMD_IDENT   = 8'h01;
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_CMD    = 8'h04;
   localparam logic [7:0]  ADDR_STAT   = 8'h08;
   localparam int          CTRL_DTYPE  = 0;
   localparam int          CTRL_RSSI   = 1;
   localparam int          CTRL_SYNC   = 2;
   localparam logic [2:0]  CTRL_RST    = 3'h0;
   localparam logic [1:0]  AXI_OKAY    = 2'h0;
   localparam logic [1:0]  AXI_SLVERR  = 2'h2;
   localparam int unsigned AWAKE_TIME_S = 30;
   localparam int unsigned CLK_HZ       = 20000000;
   localparam int unsigned AWAKE_CYC    = AWAKE_TIME_S * CLK_HZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR  = 3'b001,
      ST_LBL  = 3'b010,
      ST_TAIL = 3'b011,
      ST_RSSI = 3'b100,
      ST_SUM  = 3'b101
   } nif_st_e;

   typedef struct packed {
      nif_st_e                     st;
      logic [4:0]                  pos;
      logic [7:0]                  sum;
      logic [4:0]                  lcnt;
      logic [LBL_DEPTH-1:0][7:0]   lbl;
      logic [63:0]                 src;
      logic [63:0]                 rem;
      logic [7:0]                  opt;
      logic [7:0]                  role;
      logic [7:0]                  evt;
      logic [31:0]                 dtype;
      logic [7:0]                  rssi;
      logic                        inc_dt;
      logic                        inc_rs;
      logic [7:0]                  tx_data;
      logic                        tx_valid;
      logic                        rx_ready;
      logic                        assoc;
      logic                        id_req;
      logic [7:0]                  frames;
      logic [2:0]                  ctrl;
      logic                        btn1;
      logic                        btn2;
      logic                        btn3;
      logic [29:0]                 awake;
      logic                        awready;
      logic                        wready;
      logic                        aw_got;
      logic                        w_got;
      logic [7:0]                  waddr;
      logic [31:0]                 wdata;
      logic [3:0]                  wstrb;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        arready;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
   } nif_state_s;
endpackage

// file: hdl/nif_framer.sv
// node identification indicator framer: builds the serial frame sent to the local host
// assumes radio-side inputs on CORE_CLK, a byte sink with valid/ready, and an AXI4-Lite master
`timescale 1ns/10ps
module nif_framer #(
   parameter logic [29:0] AWAKE_CYC = 30'(nif_pkg::AWAKE_CYC),
   parameter logic [15:0] PROFILE_ID = 16'h1234, // arbitrary value
   parameter logic [15:0] MFG_ID     = 16'h5678  // arbitrary value
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic        CLK_EN,
   input  wire logic        BUTTON_N,
   input  wire logic        SYNC_MSG,
   input  wire logic        RX_VALID,
   input  wire logic [63:0] RX_SRC_ADDR,
   input  wire logic [63:0] RX_REMOTE_ADDR,
   input  wire logic [7:0]  RX_OPTIONS,
   input  wire logic [1:0]  RX_ROLE,
   input  wire logic [7:0]  RX_EVENT,
   input  wire logic [31:0] RX_DEVTYPE,
   input  wire logic [7:0]  RX_RSSI,
   input  wire logic        RX_LBL_VALID,
   input  wire logic [7:0]  RX_LBL_DATA,
   output logic             RX_READY,
   output logic [7:0]       TX_DATA,
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   output logic             ASSOC_PULSE,
   output logic             ID_BCAST_REQ,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   nif_pkg::nif_state_s r_r;
   nif_pkg::nif_state_s r_nxt;
   logic [199:0]        hdr_vec;
   logic [95:0]         tail_vec;
   logic [4:0]          lch;
   logic [15:0]         len;
   logic [7:0]          b;
   logic                press;
   logic                cmd_hit;
   logic                awake_hit;
   logic                take_rx;

   always_comb begin
      r_nxt     = r_r;
      b         = nif_pkg::NUL_BYTE;
      press     = 1'b0;
      cmd_hit   = 1'b0;
      awake_hit = 1'b0;
      take_rx   = 1'b0;
      // an empty label still occupies two bytes: one pad character and the terminator
      lch = (r_r.lcnt == 5'h00) ? 5'h01 : r_r.lcnt;
      len = nif_pkg::LEN_BASE + 16'(lch) + 16'h0001
            + (r_r.inc_dt ? nif_pkg::LEN_DTYPE : 16'h0000)
            + (r_r.inc_rs ? nif_pkg::LEN_RSSI : 16'h0000);
      hdr_vec = {nif_pkg::SOF_BYTE, len, nif_pkg::FRAME_TYPE,
                 r_r.src, nif_pkg::RSVD_FILL, r_r.opt,
                 nif_pkg::RSVD_FILL, r_r.rem};
      tail_vec = {nif_pkg::RSVD_FILL, r_r.role, r_r.evt,
                  PROFILE_ID, MFG_ID, r_r.dtype};

      // pushbutton: two-stage synchroniser, then falling-edge detect on later stages
      r_nxt.btn1 = BUTTON_N;
      r_nxt.btn2 = r_r.btn1;
      r_nxt.btn3 = r_r.btn2;
      press = r_r.btn3 & ~r_r.btn2;

      // sync-sleep awake timer; a sync message restarts the wait
      if (!r_r.ctrl[nif_pkg::CTRL_SYNC] || SYNC_MSG) begin
         r_nxt.awake = 30'h0000_0000;
      end else if (r_r.awake == AWAKE_CYC - 30'h0000_0001) begin
         r_nxt.awake = 30'h0000_0000;
         awake_hit = 1'b1;
      end else begin
         r_nxt.awake = r_r.awake + 30'h0000_0001;
      end

      // register writes: address and data may arrive in either order
      if (r_r.bvalid && S_AXI_BREADY) begin
         r_nxt.bvalid = 1'b0;
      end
      if (S_AXI_AWVALID && r_r.awready) begin
         r_nxt.aw_got = 1'b1;
         r_nxt.waddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && r_r.wready) begin
         r_nxt.w_got = 1'b1;
         r_nxt.wdata = S_AXI_WDATA;
         r_nxt.wstrb = S_AXI_WSTRB;
      end
      if (r_r.aw_got && r_r.w_got && !r_r.bvalid) begin
         r_nxt.aw_got = 1'b0;
         r_nxt.w_got  = 1'b0;
         r_nxt.bvalid = 1'b1;
         r_nxt.bresp  = nif_pkg::AXI_OKAY;
         case (r_r.waddr)
            nif_pkg::ADDR_CTRL: begin
               if (r_r.wstrb[0]) begin
                  r_nxt.ctrl = r_r.wdata[2:0];
               end
            end
            nif_pkg::ADDR_CMD: begin
               cmd_hit = r_r.wstrb[0] && (r_r.wdata[7:0] == nif_pkg::CMD_IDENT);
            end
            nif_pkg::ADDR_STAT: begin
               // status is read-only; the write is acknowledged and dropped
               r_nxt.bresp = nif_pkg::AXI_OKAY;
            end
            default: begin
               r_nxt.bresp = nif_pkg::AXI_SLVERR;
            end
         endcase
      end
      r_nxt.awready = !r_nxt.aw_got && !r_nxt.bvalid;
      r_nxt.wready  = !r_nxt.w_got && !r_nxt.bvalid;

      // register reads
      if (r_r.rvalid && S_AXI_RREADY) begin
         r_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && r_r.arready) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rresp  = nif_pkg::AXI_OKAY;
         case (S_AXI_ARADDR)
            nif_pkg::ADDR_CTRL: begin
               r_nxt.rdata = {29'h0000_0000, r_r.ctrl};
            end
            nif_pkg::ADDR_CMD: begin
               r_nxt.rdata = 32'h0000_0000;
            end
            nif_pkg::ADDR_STAT: begin
               r_nxt.rdata = {16'h0000, r_r.frames, 7'h00,
                              (r_r.st != nif_pkg::ST_IDLE) || r_r.tx_valid};
            end
            default: begin
               r_nxt.rdata = 32'h0000_0000;
               r_nxt.rresp = nif_pkg::AXI_SLVERR;
            end
         endcase
      end
      r_nxt.arready = !r_nxt.rvalid;

      // label bytes are only taken while no frame is being built
      if (r_r.rx_ready && RX_VALID) begin
         take_rx = 1'b1;
      end else if (r_r.rx_ready && RX_LBL_VALID && (r_r.lcnt < nif_pkg::LBL_MAX)) begin
         r_nxt.lbl[r_r.lcnt] = RX_LBL_DATA;
         r_nxt.lcnt = r_r.lcnt + 5'h01;
      end

      if (take_rx) begin
         r_nxt.st     = nif_pkg::ST_HDR;
         r_nxt.pos    = 5'h00;
         r_nxt.sum    = 8'h00;
         r_nxt.src    = RX_SRC_ADDR;
         r_nxt.rem    = RX_REMOTE_ADDR;
         // keep method bits and bit 3, clear reserved bits, always flag broadcast
         r_nxt.opt    = (RX_OPTIONS & nif_pkg::OPT_KEEP) | nif_pkg::OPT_BCAST;
         r_nxt.role   = {6'h00, RX_ROLE};
         r_nxt.evt    = RX_EVENT;
         r_nxt.dtype  = RX_DEVTYPE;
         r_nxt.rssi   = RX_RSSI;
         // options are frozen per frame so the length field matches the bytes sent
         r_nxt.inc_dt = r_r.ctrl[nif_pkg::CTRL_DTYPE];
         r_nxt.inc_rs = r_r.ctrl[nif_pkg::CTRL_RSSI];
         // a pending checksum byte taken at this edge must not be offered twice
         if (TX_READY) begin
            r_nxt.tx_valid = 1'b0;
         end
      end else if (!r_r.tx_valid || TX_READY) begin
         r_nxt.tx_valid = 1'b0;
         if (r_r.st != nif_pkg::ST_IDLE) begin
            r_nxt.tx_valid = 1'b1;
            r_nxt.pos = r_r.pos + 5'h01;
            case (r_r.st)
               nif_pkg::ST_HDR: begin
                  b = hdr_vec[(32'(nif_pkg::HDR_LAST) - 32'(r_r.pos)) * 8 +: 8];
                  if (r_r.pos == nif_pkg::HDR_LAST) begin
                     r_nxt.st  = nif_pkg::ST_LBL;
                     r_nxt.pos = 5'h00;
                  end
               end
               nif_pkg::ST_LBL: begin
                  if (r_r.pos == lch) begin
                     b = nif_pkg::NUL_BYTE;
                     r_nxt.st  = nif_pkg::ST_TAIL;
                     r_nxt.pos = 5'h00;
                  end else if (r_r.lcnt == 5'h00) begin
                     b = nif_pkg::PAD_CHAR;
                  end else begin
                     b = r_r.lbl[r_r.pos];
                  end
               end
               nif_pkg::ST_TAIL: begin
                  b = tail_vec[(32'(nif_pkg::TAIL_LAST_L) - 32'(r_r.pos)) * 8 +: 8];
                  if (r_r.pos == (r_r.inc_dt ? nif_pkg::TAIL_LAST_L : nif_pkg::TAIL_LAST_S)) begin
                     r_nxt.pos = 5'h00;
                     r_nxt.st  = r_r.inc_rs ? nif_pkg::ST_RSSI : nif_pkg::ST_SUM;
                  end
               end
               nif_pkg::ST_RSSI: begin
                  b = r_r.rssi;
                  r_nxt.st = nif_pkg::ST_SUM;
               end
               nif_pkg::ST_SUM: begin
                  b = nif_pkg::CKS_BASE - r_r.sum;
                  r_nxt.st     = nif_pkg::ST_IDLE;
                  r_nxt.lcnt   = 5'h00;
                  r_nxt.frames = r_r.frames + 8'h01;
               end
               default: begin
                  r_nxt.st = nif_pkg::ST_IDLE;
               end
            endcase
            r_nxt.tx_data = b;
            if (!((r_r.st == nif_pkg::ST_HDR) && (r_r.pos < nif_pkg::SUM_FROM))) begin
               r_nxt.sum = r_r.sum + b;
            end
         end
      end

      r_nxt.rx_ready = (r_nxt.st == nif_pkg::ST_IDLE);
      r_nxt.assoc    = take_rx;
      r_nxt.id_req   = press || cmd_hit || awake_hit;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         r_r      <= '0;
         r_r.ctrl <= nif_pkg::CTRL_RST;
         r_r.btn1 <= 1'b1;
         r_r.btn2 <= 1'b1;
         r_r.btn3 <= 1'b1;
      end else if (CLK_EN) begin
         r_r <= r_nxt;
      end
   end

   assign RX_READY      = r_r.rx_ready;
   assign TX_DATA       = r_r.tx_data;
   assign TX_VALID      = r_r.tx_valid;
   assign ASSOC_PULSE   = r_r.assoc;
   assign ID_BCAST_REQ  = r_r.id_req;
   assign S_AXI_AWREADY = r_r.awready;
   assign S_AXI_WREADY  = r_r.wready;
   assign S_AXI_BRESP   = r_r.bresp;
   assign S_AXI_BVALID  = r_r.bvalid;
   assign S_AXI_ARREADY = r_r.arready;
   assign S_AXI_RDATA   = r_r.rdata;
   assign S_AXI_RRESP   = r_r.rresp;
   assign S_AXI_RVALID  = r_r.rvalid;

endmodule

// file: tb/nif_framer_properties.sv
// concurrent checks on the framer byte stream and receive handshake
// assumes one clock domain; the byte index helper restarts whenever TX_VALID is low between frames
`timescale 1ns/10ps
module nif_framer_props (
   input wire logic       CORE_CLK,
   input wire logic       RESET,
   input wire logic       CLK_EN,
   input wire logic       RX_VALID,
   input wire logic       RX_READY,
   input wire logic [7:0] TX_DATA,
   input wire logic       TX_VALID,
   input wire logic       TX_READY,
   input wire logic       ASSOC_PULSE
);
   logic [5:0] pos_r;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // frames are shorter than 64 bytes, so a 6-bit index never wraps inside one
   always_ff @(posedge CORE_CLK) begin
      if (RESET || !TX_VALID) pos_r <= 6'h00;
      else if (TX_READY && CLK_EN) pos_r <= pos_r + 6'h01;
   end
   a_assoc_on_take: assert property (RX_VALID && RX_READY && CLK_EN |=> ASSOC_PULSE)
      else $error("association pulse missing after broadcast");
   a_assoc_single: assert property (ASSOC_PULSE && CLK_EN |=> !ASSOC_PULSE)
      else $error("association pulse longer than one cycle");
   a_rx_busy: assert property (RX_VALID && RX_READY && CLK_EN |=> !RX_READY)
      else $error("receive side still ready after broadcast");
   a_sof_follows: assert property (RX_VALID && RX_READY && CLK_EN |-> ##[1:2] (TX_VALID && TX_DATA == 8'h7E))
      else $error("start byte not offered after broadcast");
   a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
      else $error("stream byte changed before it was taken");
   a_len_msb: assert property (TX_VALID && pos_r == 6'h01 |-> TX_DATA == 8'h00)
      else $error("length high byte not zero");
   a_type_code: assert property (TX_VALID && pos_r == 6'h03 |-> TX_DATA == 8'h95)
      else $error("frame type byte wrong");
   a_rsvd_fill: assert property (TX_VALID && (pos_r == 6'h0C || pos_r == 6'h0F) |-> TX_DATA == 8'hFF)
      else $error("reserved word high byte wrong");
   a_opt_bits: assert property (TX_VALID && pos_r == 6'h0E |-> (TX_DATA & 8'h37) == 8'h02)
      else $error("option byte reserved or broadcast bit wrong");
endmodule
bind nif_framer nif_framer_props u_nif_framer_props (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
   .RX_VALID(RX_VALID), .RX_READY(RX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
   .ASSOC_PULSE(ASSOC_PULSE));

// file: tb/nif_host_model.sv
// host byte sink for the framer output: resyncs on the start byte and sums each frame
// assumes no byte escaping and TX_VALID held until each byte is taken
`timescale 1ns/10ps
module nif_host_model (
   input  wire logic       CORE_CLK,
   input  wire logic       RESET,
   input  wire logic [7:0] TX_DATA,
   input  wire logic       TX_VALID,
   input  wire logic       SLOW,
   output logic            TX_READY
);
   logic [7:0] fr [0:63];
   logic [7:0] sum;
   int         cnt;
   int         fr_len;
   int         n_frames;
   int         n_bad;
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         TX_READY <= 1'b0;
         cnt = 0;
         n_frames = 0;
         n_bad = 0;
      end else begin
         // a slow host is ready on every other cycle only
         TX_READY <= SLOW ? !TX_READY : 1'b1;
         if (TX_VALID === 1'b1 && TX_READY === 1'b1 && (cnt > 0 || TX_DATA === 8'h7E)) begin
            fr[cnt] = TX_DATA;
            cnt++;
         end
         // reserved words and option bits are kept as bytes, never interpreted
         if (cnt > 3 && cnt == int'({fr[1], fr[2]}) + 4) begin
            sum = 8'h00;
            for (int k = 3; k < cnt; k++) sum += fr[k];
            if (sum !== 8'hFF) n_bad++;
            fr_len = cnt;
            n_frames++;
            cnt = 0;
         end
      end
   end
endmodule

// file: tb/tb.sv
// self-checking bench for the identification indicator framer
// assumes the host model on the byte stream; registers reached over AXI4-Lite from here
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
   localparam logic [15:0] PROF = 16'hA1B2; // arbitrary value
   localparam logic [15:0] MFG  = 16'h3C4D; // arbitrary value
   logic        clk = '0, rst = '1, btn_n = '1, sync = '0, rxv = '0, lblv = '0, slow = '0;
   logic        awv = '0, wv = '0, bre = '0, arv = '0, rre = '0;
   logic        rxr, txv, txr, assoc, idq, awr, wrd, bv, arr, rv;
   logic [7:0]  lbld = '0, opts = '0, evt = '0, awa = '0, ara = '0, rssi = '0, txd, s;
   logic [1:0]  role = '0, bresp, rresp, r;
   logic [31:0] wd = '0, rdat, q, dtw = 32'hDEAD_BEEF;
   // start byte inside the remote address: it must go out unescaped
   logic [63:0] src = 64'h0013_A200_1234_5678, rem = 64'h7E55_AA01_0203_0405;
   logic [7:0]  ex [0:63];
   int          error_cnt = 0, num_checks = 0, n_assoc = 0, n_id = 0, ne, n0;
   nif_framer #(.AWAKE_CYC(30'h32), .PROFILE_ID(PROF), .MFG_ID(MFG)) u_nif_framer (
      .CORE_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .BUTTON_N(btn_n), .SYNC_MSG(sync), .RX_VALID(rxv),
      .RX_SRC_ADDR(src), .RX_REMOTE_ADDR(rem), .RX_OPTIONS(opts), .RX_ROLE(role), .RX_EVENT(evt),
      .RX_DEVTYPE(dtw), .RX_RSSI(rssi), .RX_LBL_VALID(lblv), .RX_LBL_DATA(lbld), .RX_READY(rxr),
      .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr), .ASSOC_PULSE(assoc), .ID_BCAST_REQ(idq),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
   nif_host_model u_nif_host_model (.CORE_CLK(clk), .RESET(rst), .TX_DATA(txd), .TX_VALID(txv), .SLOW(slow),
      .TX_READY(txr));
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      n_assoc += (assoc === 1'b1);
      n_id += (idq === 1'b1);
   end
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function void put(input logic [7:0] b);
      ex[ne] = b;
      ne++;
   endfunction
   task axi(input bit wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic [1:0] rr);
      bit ta;
      bit tw;
      ta = 0;
      tw = !wr;
      rq = 32'h0;
      @(posedge clk);
      if (wr) {awa, wd, awv, wv, bre} <= {a, d, 3'b111};
      else {ara, arv, rre} <= {a, 2'b11};
      forever begin
         @(posedge clk);
         if (!ta && (wr ? awr : arr) === 1'b1) begin
            ta = 1'b1;
            awv <= 1'b0;
            arv <= 1'b0;
         end
         if (!tw && wrd === 1'b1) begin
            tw = 1'b1;
            wv <= 1'b0;
         end
         if (wr && bv === 1'b1) begin
            rr = bresp;
            bre <= 1'b0;
         end
         if (!wr && rv === 1'b1) begin
            rq = rdat;
            rr = rresp;
            rre <= 1'b0;
         end
         if ((wr ? bv : rv) === 1'b1) break;
      end
   endtask
   task frame(input int n, input logic [7:0] op, input logic [1:0] rl, input logic [7:0] ev, input logic [1:0] ct);
      axi(1, nif_pkg::ADDR_CTRL, {30'h0, ct}, q, r);
      n0 = u_nif_host_model.n_frames;
      {opts, role, evt, src[7:0], rssi, slow} <= {op, rl, ev, op, 8'(n), ct[1]};
      do @(posedge clk); while (rxr !== 1'b1);
      for (int i = 0; i < n; i++) begin
         {lblv, lbld} <= {1'b1, 8'h41 + 8'(i)};
         @(posedge clk);
      end
      {lblv, rxv} <= 2'b01;
      @(posedge clk);
      rxv <= 1'b0;
      ne = 0;
      put(8'h7E); put(8'h00); put(8'h00); put(8'h95);
      for (int i = 7; i >= 0; i--) put(i == 0 ? op : src[i*8 +: 8]);
      put(8'hFF); put(8'hFE); put((op & 8'hC8) | 8'h02); put(8'hFF); put(8'hFE);
      for (int i = 7; i >= 0; i--) put(rem[i*8 +: 8]);
      for (int i = 0; i < (n > 20 ? 20 : n); i++) put(8'h41 + 8'(i));
      if (n == 0) put(8'h20);
      put(8'h00); put(8'hFF); put(8'hFE); put({6'h0, rl}); put(ev);
      put(PROF[15:8]); put(PROF[7:0]); put(MFG[15:8]); put(MFG[7:0]);
      if (ct[0]) for (int i = 3; i >= 0; i--) put(dtw[i*8 +: 8]);
      if (ct[1]) put(8'(n));
      ex[2] = 8'(ne - 3);
      s = 8'h00;
      for (int i = 3; i < ne; i++) s += ex[i];
      put(8'hFF - s);
      do @(posedge clk); while (u_nif_host_model.n_frames == n0);
      `CHK("frame size", ne, u_nif_host_model.fr_len)
      for (int i = 0; i < ne; i++) `CHK("frame byte", ex[i], u_nif_host_model.fr[i])
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      axi(0, nif_pkg::ADDR_CTRL, 32'h0, q, r);
      `CHK("control reset value", 32'h0, q)
      axi(0, 8'h0C, 32'h0, q, r);
      `CHK("unmapped read response", nif_pkg::AXI_SLVERR, r)
      axi(1, 8'h10, 32'h1, q, r);
      `CHK("unmapped write response", nif_pkg::AXI_SLVERR, r)
      axi(1, nif_pkg::ADDR_STAT, 32'h1, q, r);
      `CHK("status write response", nif_pkg::AXI_OKAY, r)
      axi(0, nif_pkg::ADDR_CMD, 32'h0, q, r);
      `CHK("command read value", 32'h0, q)
      $display("test registers done");
      frame(4, 8'hC0, 2'h1, 8'h01, 2'h0);
      frame(0, 8'h3D, 2'h0, 8'h00, 2'h3);
      frame(22, 8'h80, 2'h2, 8'h01, 2'h1);
      frame(3, 8'h42, 2'h2, 8'h01, 2'h2);
      `CHK("association pulses", 4, n_assoc)
      `CHK("host checksum errors", 0, u_nif_host_model.n_bad)
      axi(0, nif_pkg::ADDR_STAT, 32'h0, q, r);
      `CHK("frame count", 8'h04, q[15:8])
      `CHK("idle status", 1'b0, q[0])
      $display("test frames done");
      n0 = n_id;
      axi(1, nif_pkg::ADDR_CMD, 32'h1, q, r);
      axi(1, nif_pkg::ADDR_CMD, 32'h2, q, r);
      btn_n <= 1'b0;
      repeat (6) @(posedge clk);
      btn_n <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK("identify requests", n0 + 2, n_id)
      n0 = n_id;
      axi(1, nif_pkg::ADDR_CTRL, 32'h4, q, r);
      repeat (160) @(posedge clk);
      `CHK("awake identify requests", n0 + 3, n_id)
      n0 = n_id;
      sync <= 1'b1;
      repeat (160) @(posedge clk);
      `CHK("synced identify requests", n0, n_id)
      sync <= 1'b0;
      axi(1, nif_pkg::ADDR_CTRL, 32'h0, q, r);
      $display("test identify requests done");
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      close_out;
   end
endmodule
